// *** hw/uhc_port.sv ***
// Summary of operation
// - Answer command and data addresses only
// - Transfer lasts until stop or start
// - Command address refuses read direction
// - Each command byte acknowledged and forwarded
// - Data write bytes acknowledged and forwarded
// - Data read sends bytes to master
// - Master not-acknowledge ends sending, releases data
// - Repeated start begins new transfer
// - Works with serial clock to 1 MHz
// - Assert interrupt when service is needed
// - Data meaning follows latest command code
// - Shared codes split by data direction
// - Decode initialization command codes
// - Decode data flow command codes
// - Decode buffer command codes
// - Decode hub port command codes
// - Decode general command codes
// - Interrupt output is active low
`default_nettype none
module uhc_port (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Serial clock pin, open drain
	input  wire logic             scl_i,
	output logic                  scl_o,
	output logic                  scl_oe_o,
	// Serial data pin, open drain
	input  wire logic             sda_i,
	output logic                  sda_o,
	output logic                  sda_oe_o,
	// Interrupt pin, open drain, active low
	input  wire logic             irq_req_i,
	output logic                  int_n_o,
	output logic                  int_n_oe_o,
	// Received bytes toward the memory manager
	output logic                  rx_valid_o,
	input  wire logic             rx_ready_i,
	output uhc_pkg::uhc_word_s    rx_word_o,
	// Bytes to send to the master
	input  wire logic             tx_valid_i,
	output logic                  tx_ready_o,
	input  wire logic [7:0]       tx_data_i,
	output uhc_pkg::uhc_word_s    tx_info_o
);

	// Command decoder, direction picks among shared codes
	function automatic uhc_pkg::uhc_class_e cmd_class(input logic [7:0] c, input logic rd);
		uhc_pkg::uhc_class_e k;
		k = uhc_pkg::CL_UNKNOWN;
		if (c <= uhc_pkg::C_EP_LAST)
			k = uhc_pkg::CL_SEL_EP;
		else if (c >= uhc_pkg::C_LAST_ST && c <= (uhc_pkg::C_LAST_ST | uhc_pkg::C_EP_LAST))
			k = rd ? uhc_pkg::CL_LAST_ST : uhc_pkg::CL_SET_EP_ST;
		else if (c >= uhc_pkg::C_EP_ST && c <= (uhc_pkg::C_EP_ST | uhc_pkg::C_EP_LAST))
			k = uhc_pkg::CL_EP_ST;
		else if (c[7:2] == uhc_pkg::C_SET_ADDR[7:2])
			k = uhc_pkg::CL_SET_ADDR;
		else if (c[7:2] == uhc_pkg::C_PORT_CLR[7:2])
			k = rd ? uhc_pkg::CL_PORT_ST : uhc_pkg::CL_PORT_CLR;
		else if (c[7:2] == uhc_pkg::C_PORT_SET[7:2])
			k = uhc_pkg::CL_PORT_SET;
		else
		begin
			case (c)
				uhc_pkg::C_EP_EN:    k = uhc_pkg::CL_EP_EN;
				uhc_pkg::C_MODE:     k = uhc_pkg::CL_SET_MODE;
				uhc_pkg::C_IRQ_RD:   k = uhc_pkg::CL_IRQ_RD;
				uhc_pkg::C_BUF:      k = rd ? uhc_pkg::CL_BUF_RD : uhc_pkg::CL_BUF_WR;
				uhc_pkg::C_ACK_SU:   k = uhc_pkg::CL_ACK_SETUP;
				uhc_pkg::C_CLR_BUF:  k = uhc_pkg::CL_CLR_BUF;
				uhc_pkg::C_VALIDATE: k = uhc_pkg::CL_VALIDATE;
				uhc_pkg::C_CHG_BITS: k = uhc_pkg::CL_CHG_BITS;
				uhc_pkg::C_RESUME:   k = uhc_pkg::CL_RESUME;
				uhc_pkg::C_FRAME:    k = uhc_pkg::CL_FRAME;
				default:             k = uhc_pkg::CL_UNKNOWN;
			endcase
		end
		return k;
	endfunction

	// Pin synchronisers, two stages each
	logic [1:0]           scl_sync_r;   // Serial clock stages
	logic [1:0]           sda_sync_r;   // Serial data stages
	logic                 scl_d_r;      // Serial clock, one cycle older
	logic                 sda_d_r;      // Serial data, one cycle older
	// Bus engine state
	uhc_pkg::uhc_state_e  st_r;         // Bus state
	logic [2:0]           bit_cnt_r;    // Bits seen in this byte
	logic [7:0]           sh_r;         // Shift register
	logic                 byte_done_r;  // Eighth bit clocked, waiting for low clock
	logic                 is_cmd_r;     // Current transfer is at command address
	logic                 rw_r;         // Current transfer direction, one reads
	logic                 load_r;       // Next byte to send is wanted
	logic                 mack_r;       // Master answered the last byte
	logic                 mack_seen_r;  // Acknowledge bit clocked, ours or the master's
	logic                 sda_oe_r;     // Holding data low
	logic                 scl_oe_r;     // Stretching the clock
	logic [7:0]           cmd_r;        // Latest command code
	logic [3:0]           idx_r;        // Data phase byte count
	logic                 irq_r;        // Registered interrupt request
	// Derived events
	logic                 scl_s;        // Synchronised serial clock
	logic                 sda_s;        // Synchronised serial data
	logic                 scl_rise;     // Serial clock rising edge
	logic                 start_det;    // Start or repeated start
	logic                 stop_det;     // Stop
	logic                 push;         // Received byte enters buffer
	logic                 pop;          // Buffer word taken
	uhc_pkg::uhc_word_s   push_word;    // Word to store
	// Receive buffer
	uhc_pkg::uhc_word_s   buf_r [uhc_pkg::BUF_DEPTH];  // Storage
	logic                 wp_r;         // Write index
	logic                 rp_r;         // Read index
	logic [1:0]           cnt_r;        // Occupancy
	logic                 buf_ready;    // Room for one more

	// Two flops on each pin, margin is ample at the fastest serial clock
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_d_r    <= 1'h1;
			sda_d_r    <= 1'h1;
		end
		else
		begin
			scl_sync_r <= {scl_sync_r[0], scl_i};
			sda_sync_r <= {sda_sync_r[0], sda_i};
			scl_d_r    <= scl_sync_r[1];
			sda_d_r    <= sda_sync_r[1];
		end
	end

	// Edge and condition detection on synchronised levels
	assign scl_s     = scl_sync_r[1];
	assign sda_s     = sda_sync_r[1];
	assign scl_rise  = scl_s && !scl_d_r;
	assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_det  = scl_s && scl_d_r && !sda_d_r && sda_s;

	// Byte ready for the buffer once the clock is low after bit eight
	assign push = (st_r == uhc_pkg::ST_RX) && byte_done_r && !scl_s && buf_ready;
	// Next send byte taken while the clock is low
	assign tx_ready_o = (st_r == uhc_pkg::ST_TX) && load_r && !scl_s;

	// Word to forward, data meaning follows the latest command
	always_comb
	begin
		push_word        = '0;
		push_word.is_cmd = is_cmd_r;
		push_word.data   = sh_r;
		push_word.idx    = idx_r;
		if (is_cmd_r)
		begin
			push_word.cls = cmd_class(sh_r, 1'b0);
			push_word.sel = sh_r[3:0];
		end
		else
		begin
			push_word.cls = cmd_class(cmd_r, 1'b0);
			push_word.sel = cmd_r[3:0];
		end
	end

	// Bus engine
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			st_r        <= uhc_pkg::ST_IDLE;
			bit_cnt_r   <= '0;
			sh_r        <= '0;
			byte_done_r <= 1'b0;
			is_cmd_r    <= 1'b0;
			rw_r        <= 1'b0;
			load_r      <= 1'b0;
			mack_r      <= 1'b0;
			mack_seen_r <= 1'b0;
			sda_oe_r    <= 1'b0;
			scl_oe_r    <= 1'b0;
		end
		else if (stop_det)
		begin
			// Stop ends any transfer and releases both lines
			st_r     <= uhc_pkg::ST_IDLE;
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
			load_r   <= 1'b0;
			// Drop a half-seen acknowledge so the next transfer starts clean
			mack_seen_r <= 1'b0;
		end
		else if (start_det)
		begin
			// Start or repeated start opens a new address phase
			st_r        <= uhc_pkg::ST_ADDR;
			bit_cnt_r   <= '0;
			byte_done_r <= 1'b0;
			sda_oe_r    <= 1'b0;
			scl_oe_r    <= 1'b0;
			load_r      <= 1'b0;
			mack_seen_r <= 1'b0;
		end
		else
		begin
			case (st_r)
				uhc_pkg::ST_ADDR, uhc_pkg::ST_RX:
				begin
					// Sample bits most significant first on rising clock
					if (scl_rise && !byte_done_r)
					begin
						sh_r        <= {sh_r[6:0], sda_s};
						bit_cnt_r   <= bit_cnt_r + 3'h1;
						byte_done_r <= (bit_cnt_r == uhc_pkg::LAST_BIT);
					end
					else if (byte_done_r && !scl_s && st_r == uhc_pkg::ST_ADDR)
					begin
						byte_done_r <= 1'b0;
						is_cmd_r    <= (sh_r[7:1] == uhc_pkg::CMD_ADDR);
						rw_r        <= sh_r[0];
						// Answer only our two addresses, command write only
						if ((sh_r[7:1] == uhc_pkg::CMD_ADDR && !sh_r[0]) || sh_r[7:1] == uhc_pkg::DATA_ADDR)
						begin
							sda_oe_r <= 1'b1;
							st_r     <= uhc_pkg::ST_ADDR_ACK;
						end
						else
							st_r <= uhc_pkg::ST_DONE;
					end
					else if (byte_done_r && !scl_s)
					begin
						// Stretch the clock while the buffer is full
						if (push)
						begin
							byte_done_r <= 1'b0;
							sda_oe_r    <= 1'b1;
							scl_oe_r    <= 1'b0;
							st_r        <= uhc_pkg::ST_RX_ACK;
						end
						else
							scl_oe_r <= 1'b1;
					end
				end
				uhc_pkg::ST_ADDR_ACK, uhc_pkg::ST_RX_ACK:
				begin
					// Release acknowledge after its clock pulse
					if (scl_rise)
						mack_seen_r <= 1'b1;
					else if (mack_seen_r && !scl_s)
					begin
						mack_seen_r <= 1'b0;
						sda_oe_r    <= 1'b0;
						bit_cnt_r   <= '0;
						if (st_r == uhc_pkg::ST_ADDR_ACK && rw_r)
						begin
							st_r   <= uhc_pkg::ST_TX;
							load_r <= 1'b1;
						end
						else
							st_r <= uhc_pkg::ST_RX;
					end
				end
				uhc_pkg::ST_TX:
				begin
					if (load_r)
					begin
						// Load a byte, stretching until the source has one
						if (tx_ready_o && tx_valid_i)
						begin
							sh_r      <= tx_data_i;
							sda_oe_r  <= !tx_data_i[7];
							scl_oe_r  <= 1'b0;
							load_r    <= 1'b0;
							bit_cnt_r <= '0;
						end
						else if (!scl_s)
							scl_oe_r <= 1'b1;
					end
					else if (scl_rise)
					begin
						bit_cnt_r   <= bit_cnt_r + 3'h1;
						byte_done_r <= (bit_cnt_r == uhc_pkg::LAST_BIT);
					end
					else if (scl_d_r && !scl_s)
					begin
						// Falling clock: next bit, or free the line for the answer
						if (byte_done_r)
						begin
							byte_done_r <= 1'b0;
							sda_oe_r    <= 1'b0;
							st_r        <= uhc_pkg::ST_MACK;
						end
						else
						begin
							sh_r     <= {sh_r[6:0], 1'b0};
							sda_oe_r <= !sh_r[6];
						end
					end
				end
				uhc_pkg::ST_MACK:
				begin
					// Master low means more wanted, high ends sending
					if (scl_rise)
					begin
						mack_r      <= !sda_s;
						mack_seen_r <= 1'b1;
					end
					else if (mack_seen_r && !scl_s)
					begin
						mack_seen_r <= 1'b0;
						if (mack_r)
						begin
							st_r   <= uhc_pkg::ST_TX;
							load_r <= 1'b1;
						end
						else
							st_r <= uhc_pkg::ST_DONE;
					end
				end
				uhc_pkg::ST_IDLE, uhc_pkg::ST_DONE:
				begin
					// Lines released, wait for the next start or stop
					sda_oe_r <= 1'b0;
					scl_oe_r <= 1'b0;
				end
				default:
					st_r <= uhc_pkg::ST_IDLE;
			endcase
		end
	end

	// Latest command code and data phase position
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			cmd_r <= uhc_pkg::CMD_RST;
			idx_r <= uhc_pkg::IDX_RST;
		end
		else if (st_r == uhc_pkg::ST_ADDR_ACK)
			idx_r <= uhc_pkg::IDX_RST;
		else if (push && is_cmd_r)
			cmd_r <= sh_r;
		else if ((push || (tx_ready_o && tx_valid_i)) && idx_r != uhc_pkg::IDX_MAX)
			idx_r <= idx_r + 4'h1;
	end

	// Two entry buffer toward the memory manager
	assign buf_ready = (cnt_r != 2'h2);
	assign pop       = rx_valid_o && rx_ready_i;
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
			cnt_r <= 2'h0;
		end
		else
		begin
			if (push)
			begin
				buf_r[wp_r] <= push_word;
				wp_r        <= !wp_r;
			end
			if (pop)
				rp_r <= !rp_r;
			if (push && !pop)
				cnt_r <= cnt_r + 2'h1;
			else if (pop && !push)
				cnt_r <= cnt_r - 2'h1;
		end
	end
	assign rx_valid_o = (cnt_r != 2'h0);
	assign rx_word_o  = rx_valid_o ? buf_r[rp_r] : '0;

	// Context for the byte being sent, read variant of the command
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			tx_info_o <= '0;
		else
		begin
			tx_info_o.is_cmd <= 1'b0;
			tx_info_o.cls    <= cmd_class(cmd_r, 1'b1);
			tx_info_o.sel    <= cmd_r[3:0];
			tx_info_o.idx    <= idx_r;
			tx_info_o.data   <= '0;
		end
	end

	// Interrupt line pulled low while service is requested
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			irq_r <= 1'b0;
		else
			irq_r <= irq_req_i;
	end

	// Open drain pins only ever pull low
	assign scl_o      = 1'b0;
	assign sda_o      = 1'b0;
	assign scl_oe_o   = scl_oe_r;
	assign sda_oe_o   = sda_oe_r;
	assign int_n_o    = 1'b0;
	assign int_n_oe_o = irq_r;

endmodule
`default_nettype wire

// *** hw/uhc_pkg.sv ***
`default_nettype none
// Shared constants and types for the hub command port
package uhc_pkg;
	// Slave addresses, seven bits each
	localparam logic [6:0] CMD_ADDR  = 7'h1B;   // Command transfers
	localparam logic [6:0] DATA_ADDR = 7'h1A;   // Data transfers
	// Bit counter value of the last bit in a byte
	localparam logic [2:0] LAST_BIT  = 3'h7;
	// Data phase byte index reset value and ceiling
	localparam logic [3:0] IDX_RST   = 4'h0;
	localparam logic [3:0] IDX_MAX   = 4'hF;
	// Command code bases
	localparam logic [7:0] C_SEL_EP   = 8'h00;  // Plus endpoint index
	localparam logic [7:0] C_LAST_ST  = 8'h40;  // Plus endpoint index
	localparam logic [7:0] C_EP_ST    = 8'h80;  // Plus endpoint index
	localparam logic [7:0] C_EP_LAST  = 8'h0D;  // Highest endpoint index
	localparam logic [7:0] C_SET_ADDR = 8'hD0;  // Four codes
	localparam logic [7:0] C_EP_EN    = 8'hD8;
	localparam logic [7:0] C_PORT_CLR = 8'hE0;  // Four codes
	localparam logic [7:0] C_PORT_SET = 8'hE8;  // Four codes
	localparam logic [7:0] C_BUF      = 8'hF0;
	localparam logic [7:0] C_ACK_SU   = 8'hF1;
	localparam logic [7:0] C_CLR_BUF  = 8'hF2;
	localparam logic [7:0] C_MODE     = 8'hF3;
	localparam logic [7:0] C_IRQ_RD   = 8'hF4;
	localparam logic [7:0] C_FRAME    = 8'hF5;
	localparam logic [7:0] C_RESUME   = 8'hF6;
	localparam logic [7:0] C_CHG_BITS = 8'hF7;
	localparam logic [7:0] C_VALIDATE = 8'hFA;
	localparam logic [7:0] CMD_RST    = 8'hFF;  // No command yet
	// Timing: system clock and fastest serial clock
	localparam int CLK_HZ     = 250_000_000;
	localparam int SCL_MAX_HZ = 1_000_000;
	// Clock cycles in the shortest serial clock half period
	localparam int SCL_HALF_CYC = CLK_HZ / (2 * SCL_MAX_HZ);
	// Receive buffer depth
	localparam int BUF_DEPTH = 2;

	// Decoded meaning of a command code
	typedef enum logic [4:0] {
		CL_UNKNOWN, CL_SET_ADDR, CL_EP_EN, CL_SET_MODE, CL_IRQ_RD,
		CL_SEL_EP, CL_LAST_ST, CL_SET_EP_ST, CL_EP_ST, CL_BUF_RD,
		CL_BUF_WR, CL_ACK_SETUP, CL_CLR_BUF, CL_VALIDATE, CL_PORT_CLR,
		CL_PORT_ST, CL_PORT_SET, CL_CHG_BITS, CL_RESUME, CL_FRAME
	} uhc_class_e;

	// Bus state of the slave
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_MACK, ST_DONE
	} uhc_state_e;

	// One received byte on its way to the memory manager
	typedef struct packed {
		logic       is_cmd;   // Byte is a command code
		uhc_class_e cls;      // Command it belongs to
		logic [3:0] sel;      // Endpoint, port or function index
		logic [3:0] idx;      // Position within the data phase
		logic [7:0] data;     // The byte itself
	} uhc_word_s;
endpackage
`default_nettype wire

// *** tb/uhc_port_checker.sv ***
`default_nettype none
// Port-level checks for the hub command port
module uhc_port_checker (
	// Clock and reset
	input wire logic               clk_i,
	input wire logic               rst_n_i,
	// Serial pins
	input wire logic               scl_i,
	input wire logic               scl_o,
	input wire logic               scl_oe_o,
	input wire logic               sda_o,
	input wire logic               sda_oe_o,
	// Interrupt
	input wire logic               irq_req_i,
	input wire logic               int_n_o,
	input wire logic               int_n_oe_o,
	// Streams
	input wire logic               rx_valid_o,
	input wire logic               rx_ready_i,
	input wire uhc_pkg::uhc_word_s rx_word_o,
	input wire logic               tx_valid_i,
	input wire logic               tx_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// One clock domain throughout
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_irq_assert: assert property (irq_req_i |=> int_n_oe_o)
		else $error("interrupt line not pulled");
	a_irq_release: assert property (!irq_req_i |=> !int_n_oe_o)
		else $error("interrupt line not released");
	a_od_levels: assert property (!scl_o && !sda_o && !int_n_o)
		else $error("open drain value high");
	a_rx_hold: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_word_o))
		else $error("word lost while stalled");
	a_rx_empty: assert property (!rx_valid_o |-> rx_word_o == '0)
		else $error("empty buffer shows a word");
	a_rx_drop: assert property ($fell(rx_valid_o) |-> $past(rx_ready_i))
		else $error("word dropped without pop");
	a_rx_write_var: assert property (rx_valid_o |->
		rx_word_o.cls != uhc_pkg::CL_BUF_RD && rx_word_o.cls != uhc_pkg::CL_PORT_ST)
		else $error("written byte carries read class");
	a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i))
		else $error("data changed while clock high");
	a_stretch_low: assert property ($rose(scl_oe_o) |-> !$past(scl_i))
		else $error("stretch began with clock high");
	// One byte per load slot, the next waits for the master answer
	a_tx_single: assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o)
		else $error("second byte taken in one load");

	// Main scenarios reached
	c_cmd: cover property (rx_valid_o && rx_ready_i && rx_word_o.is_cmd);
	c_data: cover property (rx_valid_o && rx_ready_i && !rx_word_o.is_cmd);
	c_tx: cover property (tx_valid_i && tx_ready_o);
	c_stretch: cover property ($rose(scl_oe_o));
endmodule

bind uhc_port uhc_port_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .scl_o(scl_o),
	.scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_req_i(irq_req_i), .int_n_o(int_n_o),
	.int_n_oe_o(int_n_oe_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_word_o(rx_word_o),
	.tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o));
`default_nettype wire

// *** tb/uhc_i2c_master.sv ***
`default_nettype none
// Serial bus master driving the port at 1 MHz
module uhc_i2c_master (
	input wire logic clk_i,
	input wire logic scl_w_i,
	input wire logic sda_w_i,
	output logic     scl_m_o,
	output logic     sda_m_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int H = 125; // Half period at 1 MHz
	// Lines released at start
	initial
	begin
		scl_m_o = 1'b1;
		sda_m_o = 1'b1;
	end
	task automatic hp();
		repeat (H) @(posedge clk_i);
	endtask
	// Release clock, honour stretching, hold high
	task automatic up();
		int n;
		n = 0;
		scl_m_o <= 1'b1;
		@(posedge clk_i);
		while (scl_w_i !== 1'b1 && n < 50000)
		begin
			@(posedge clk_i);
			n++;
		end
		hp();
	endtask
	// One bit: data set in low phase, sampled late in high
	task automatic bit_x(input logic b, output logic s);
		repeat (4) @(posedge clk_i);
		sda_m_o <= b;
		hp();
		up();
		s = sda_w_i;
		scl_m_o <= 1'b0;
	endtask
	// Start, also usable as repeated start
	task automatic start();
		sda_m_o <= 1'b1;
		hp();
		up();
		sda_m_o <= 1'b0;
		hp();
		scl_m_o <= 1'b0;
	endtask
	task automatic stop();
		repeat (4) @(posedge clk_i);
		sda_m_o <= 1'b0;
		hp();
		up();
		sda_m_o <= 1'b1;
		hp();
	endtask
	// Byte out, most significant bit first
	task automatic wr(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], s);
		bit_x(1'b1, s);
		ack = ~s;
	endtask
	// Byte in; last one left unacknowledged
	task automatic rd(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, d[i]);
		bit_x(last, s);
	endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	logic               irq_req = 1'b0;
	logic               rx_ready = 1'b1;
	logic               tx_valid = 1'b1;
	logic [7:0]         tx_data = 8'h5A;
	wire logic          scl_m;
	wire logic          sda_m;
	logic               scl_oe;
	logic               sda_oe;
	logic               int_oe;
	logic               rx_valid;
	logic               tx_ready;
	uhc_pkg::uhc_word_s rx_word;
	uhc_pkg::uhc_word_s tx_info;
	uhc_pkg::uhc_word_s rxq [$];   // Words taken from the port
	int                 bad_count = 0;
	int                 checks_done = 0;
	// Pulled-up wires: low if anyone pulls
	wire logic          scl_w = scl_m & ~scl_oe;
	wire logic          sda_w = sda_m & ~sda_oe;
	// One code of every command, with its write-direction class
	logic [7:0] codes [16] = '{8'hD0, 8'hD8, 8'hF3, 8'hF4, 8'h05, 8'h42, 8'h83, 8'hF0,
		8'hF1, 8'hF2, 8'hFA, 8'hE1, 8'hE9, 8'hF7, 8'hF6, 8'hF5};
	uhc_pkg::uhc_class_e cx [16] = '{uhc_pkg::CL_SET_ADDR, uhc_pkg::CL_EP_EN, uhc_pkg::CL_SET_MODE,
		uhc_pkg::CL_IRQ_RD, uhc_pkg::CL_SEL_EP, uhc_pkg::CL_SET_EP_ST, uhc_pkg::CL_EP_ST, uhc_pkg::CL_BUF_WR,
		uhc_pkg::CL_ACK_SETUP, uhc_pkg::CL_CLR_BUF, uhc_pkg::CL_VALIDATE, uhc_pkg::CL_PORT_CLR,
		uhc_pkg::CL_PORT_SET, uhc_pkg::CL_CHG_BITS, uhc_pkg::CL_RESUME, uhc_pkg::CL_FRAME};

	always #2 clk = ~clk;
	uhc_port DUT (.clk_i(clk), .rst_n_i(rst_n), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_w),
		.sda_o(), .sda_oe_o(sda_oe), .irq_req_i(irq_req), .int_n_o(), .int_n_oe_o(int_oe),
		.rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_word_o(rx_word), .tx_valid_i(tx_valid),
		.tx_ready_o(tx_ready), .tx_data_i(tx_data), .tx_info_o(tx_info));
	uhc_i2c_master m (.clk_i(clk), .scl_w_i(scl_w), .sda_w_i(sda_w), .scl_m_o(scl_m), .sda_m_o(sda_m));
	// Consumer and byte source
	always @(posedge clk) if (rx_valid && rx_ready) rxq.push_back(rx_word);
	always @(posedge clk) if (tx_valid && tx_ready) tx_data <= tx_data + 8'h11;

	task automatic cmp(input logic [7:0] g, input logic [7:0] e, input string s);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, s, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Foreign address, reversed bit order, command read: all refused
	task automatic t_addr();
		logic a;
		logic [7:0] ad [3] = '{8'h38, 8'hD8, 8'h37};
		rxq.delete();
		foreach (ad[i])
		begin
			m.start();
			m.wr(ad[i], a);
			cmp({7'h00, a}, 8'h00, "refused address");
			m.stop();
		end
		cmp(8'(rxq.size()), 8'h00, "nothing forwarded");
		$display("t_addr done");
	endtask
	// One code of every command in one transfer
	task automatic t_cmd();
		logic a;
		rxq.delete();
		m.start();
		m.wr(8'h36, a);
		cmp({7'h00, a}, 8'h01, "command address");
		foreach (codes[i])
		begin
			m.wr(codes[i], a);
			cmp({7'h00, a}, 8'h01, "command ack");
		end
		m.stop();
		repeat (20) @(posedge clk);
		cmp(8'(rxq.size()), 8'h10, "command count");
		foreach (rxq[i])
		begin
			cmp({rxq[i].is_cmd, 2'h0, rxq[i].cls}, {1'b1, 2'h0, cx[i]}, "class");
			cmp(rxq[i].data, codes[i], "command data");
		end
		$display("t_cmd done");
	endtask
	// Buffer write after repeated start, consumer stalled
	task automatic t_dwr();
		logic a;
		logic [7:0] d [3] = '{8'hA5, 8'h3C, 8'hC3};
		rxq.delete();
		@(posedge clk);
		rx_ready <= 1'b0;
		m.start();
		m.wr(8'h36, a);
		m.wr(8'hF0, a);
		m.start();
		m.wr(8'h34, a);
		cmp({7'h00, a}, 8'h01, "data address");
		fork
			foreach (d[i])
				m.wr(d[i], a);
			begin
				repeat (6000) @(posedge clk);
				rx_ready <= 1'b1;
			end
		join
		m.stop();
		repeat (20) @(posedge clk);
		cmp(8'(rxq.size()), 8'h04, "data count");
		for (int i = 1; i < 4 && i < rxq.size(); i++)
		begin
			cmp({rxq[i].is_cmd, 2'h0, rxq[i].cls}, {3'h0, uhc_pkg::CL_BUF_WR}, "data class");
			cmp({rxq[i].idx, 4'h0}, {4'(i - 1), 4'h0}, "data index");
			cmp(rxq[i].data, d[i - 1], "data byte");
		end
		$display("t_dwr done");
	endtask
	// Port status read, two bytes, last refused by master
	task automatic t_drd();
		logic a;
		logic [7:0] b0;
		logic [7:0] b1;
		// No byte ready at first, so the port must stretch the clock
		tx_valid <= 1'b0;
		m.start();
		m.wr(8'h36, a);
		m.wr(8'hE2, a);
		m.start();
		m.wr(8'h35, a);
		cmp({7'h00, a}, 8'h01, "read address");
		fork
			m.rd(1'b0, b0);
			begin
				repeat (600) @(posedge clk);
				tx_valid <= 1'b1;
			end
		join
		cmp({3'h0, tx_info.cls}, {3'h0, uhc_pkg::CL_PORT_ST}, "read class");
		cmp({4'h0, tx_info.sel}, 8'h02, "read port");
		m.rd(1'b1, b1);
		cmp(b0, 8'h5A, "first read");
		cmp(b1, 8'h6B, "second read");
		repeat (40) @(posedge clk);
		cmp({7'h00, sda_oe}, 8'h00, "released");
		m.stop();
		$display("t_drd done");
	endtask
	// Interrupt raised then withdrawn
	task automatic t_irq();
		@(posedge clk);
		irq_req <= 1'b1;
		repeat (3) @(posedge clk);
		cmp({7'h00, int_oe}, 8'h01, "irq on");
		irq_req <= 1'b0;
		repeat (3) @(posedge clk);
		cmp({7'h00, int_oe}, 8'h00, "irq off");
		$display("t_irq done");
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		t_irq();
		t_addr();
		t_cmd();
		t_dwr();
		t_drd();
		print_verdict();
	end
	// Hang guard
	initial
	begin
		repeat (95000) @(posedge clk);
		bad_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
